// *** serial_link_test_and_multiframe_ctrl_tb.sv ***
// Self-checking testbench for the link test and multiframe control block
`timescale 1ns/1ps
module serial_link_test_and_multiframe_ctrl_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sysref = 0, hold_req = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lane_data, sample_data = 32'h11223344;
  logic pready, pslverr, err, sync_n, lane_disp_flip, mf_boundary, ilas_seen;
  logic [3:0] lane_is_k;
  logic [4:0] mf_count;
  int n_errors = 0, n_compared = 0, nb, k;
  logic [7:0] regs[4] = '{8'h04, 8'h08, 8'h0C, 8'h14}; // Mapped control words
  logic [7:0] rmask[4] = '{8'hC0, 8'hF8, 8'hFF, 8'h80}; // Readable bits of each
  logic [7:0] rpat[12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E,
    8'hFB, 8'h35, 8'h59};
  // ===================================================================
  // Clock, design and receiver model
  initial forever #12.5 pclk = ~pclk;
  sltmc_link_ctrl #(.LANES(4), .OCTETS_PER_FRAME(2)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_n(sync_n), .sysref(sysref),
    .sample_data(sample_data), .lane_data(lane_data), .lane_is_k(lane_is_k),
    .lane_disp_flip(lane_disp_flip), .mf_count(mf_count), .mf_boundary(mf_boundary));
  sltmc_rx_model #(.LANES(4)) u_rx (.pclk(pclk), .presetn(presetn), .hold_req(hold_req),
    .lane_data(lane_data), .lane_is_k(lane_is_k), .sync_n(sync_n), .ilas_seen(ilas_seen));
  // ===================================================================
  // Shared tasks
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Bounded wait guard: a spent bound ends the run as a mismatch
  task guard(input string n);
    k++;
    if (k > 3000) begin
      chk(n, 1, 0);
      report_and_stop();
    end
  endtask : guard
  // One APB transfer; request held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      guard("pready wait");
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_mf(input logic [4:0] v);
    k = 0;
    while (mf_count !== v) begin
      guard("count wait");
      @(posedge pclk);
    end
  endtask : wait_mf
  task pulse_sysref;
    @(posedge pclk) sysref <= 1'b1;
    @(posedge pclk) sysref <= 1'b0;
  endtask : pulse_sysref
  // Resync, restart from the start value, count boundaries up to the first alignment char
  task link_up(input logic [1:0] d);
    @(posedge pclk) hold_req <= 1'b1;
    apb(1'b1, 8'h0C, {24'h0, 1'b1, 5'h1C, d});
    pulse_sysref();
    wait_mf(5'h02);
    @(posedge pclk) hold_req <= 1'b0;
    k = 0;
    while (sync_n !== 1'b1) begin
      guard("sync release");
      @(posedge pclk);
    end
    pulse_sysref();
    @(posedge pclk);
    chk("restart count", 32'h1C, mf_count);
    nb = 0;
    k = 0;
    while (ilas_seen !== 1'b1) begin
      nb += mf_boundary;
      guard("alignment wait");
      @(posedge pclk);
    end
    nb += mf_boundary;
    chk("boundaries before alignment", d + 1, nb);
  endtask : link_up
  // ===================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", 32'h0, rd);
      apb(1'b1, regs[i], 32'hFF);
      apb(1'b0, regs[i], 32'h0);
      chk("readable bits", {24'h0, rmask[i]}, rd);
      apb(1'b1, regs[i], 32'h0);
    end
    apb(1'b1, 8'h40, 32'hFF);
    chk("unmapped error", 1, err);
    for (int d = 0; d < 4; d++) link_up(d[1:0]);
    repeat (264) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk("data state", 3'h6, rd[7:5]);
    chk("normal data", sample_data, lane_data);
    apb(1'b1, 8'h14, 32'h80);
    repeat (4) @(posedge pclk);
    chk("scrambled", 1, lane_data !== sample_data);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h08, 32'h30);
    repeat (4) @(posedge pclk);
    chk("d21.5 lanes", 32'hB5B5B5B5, lane_data);
    chk("flip off", 0, lane_disp_flip);
    apb(1'b1, 8'h08, 32'h50);
    repeat (4) @(posedge pclk);
    chk("k28.5 lanes", 32'hBCBCBCBC, lane_data);
    chk("k28.5 kflag", 4'hF, lane_is_k);
    apb(1'b1, 8'h08, 32'h90);
    k = 0;
    while (lane_data[7:0] !== 8'hBE) begin
      guard("pattern start");
      @(posedge pclk);
    end
    for (int j = 0; j < 12; j++) begin
      chk("jitter pattern", {4{rpat[j]}}, lane_data);
      chk("flip on", 1, lane_disp_flip);
      @(posedge pclk);
    end
    // Test patterns override the sync fill, so return to normal data first
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h04, 32'hC0);
    repeat (4) @(posedge pclk);
    chk("sw sync fill", 32'hBCBCBCBC, lane_data);
    @(posedge pclk) hold_req <= 1'b1;
    apb(1'b1, 8'h04, 32'h40);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk("pin ignored", 1, rd[7:5] != 3'h0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("pin governs", 3'h0, rd[7:5]);
    apb(1'b1, 8'h08, 32'h08);
    wait_mf(5'h0A);
    pulse_sysref();
    @(posedge pclk);
    chk("masked restart", 1, mf_count != 5'h1C);
    apb(1'b1, 8'h08, 32'h60);
    link_up(2'h0);
    repeat (512) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    chk("alignment loop", 3'h2, rd[7:5]);
    report_and_stop();
  end
endmodule : serial_link_test_and_multiframe_ctrl_tb

// *** sltmc_cfg.svh ***
// Register offsets, field positions, reset values and character codes for the link test block
`ifndef SLTMC_CFG_SVH
`define SLTMC_CFG_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define SLTMC_IDX_SYNC_CTRL 6'h01
`define SLTMC_IDX_PATTERN 6'h02
`define SLTMC_IDX_MFC_CTRL 6'h03
`define SLTMC_IDX_SCRAMBLER 6'h05
`define SLTMC_IDX_STATUS 6'h08
// =====================================================================
// Field positions
`define SLTMC_SYNC_SW_BIT 7
`define SLTMC_SYNC_SW_EN_BIT 6
`define SLTMC_PAT_SEL_HI 7
`define SLTMC_PAT_SEL_LO 5
`define SLTMC_PAT_FLIP_BIT 4
`define SLTMC_MF_IGNORE_BIT 3
`define SLTMC_PRESET_EN_BIT 7
`define SLTMC_START_HI 6
`define SLTMC_START_LO 2
`define SLTMC_DELAY_HI 1
`define SLTMC_DELAY_LO 0
`define SLTMC_SCR_EN_BIT 7
// =====================================================================
// Reset values and masks of readable bits
`define SLTMC_RST_REG 8'h00
`define SLTMC_PAT_RD_MASK 8'hF8
`define SLTMC_SYNC_RD_MASK 8'hC0
`define SLTMC_SCR_RD_MASK 8'h80
// =====================================================================
// Timing counts
`define SLTMC_MF_LAST 5'h1F
`define SLTMC_ILA_MF_LAST 2'h3
`define SLTMC_RPAT_LAST 4'hB
// =====================================================================
// Control characters and data patterns
`define SLTMC_K28_5 8'hBC
`define SLTMC_K28_0 8'h1C
`define SLTMC_K28_3 8'h7C
`define SLTMC_K28_4 8'h9C
`define SLTMC_D21_5 8'hB5
`endif

// *** sltmc_link_checker.sv ***
// Port-level checker for the link test and multiframe control block
`timescale 1ns/1ps
module sltmc_link_checker #(
  parameter int LANES = 4,
  parameter int OCTETS_PER_FRAME = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_n,
  input wire logic sysref,
  input wire logic [LANES*8-1:0] lane_data,
  input wire logic [LANES-1:0] lane_is_k,
  input wire logic lane_disp_flip,
  input wire logic [4:0] mf_count,
  input wire logic mf_boundary
);
  // ===================================================================
  // Shadow registers, loaded at the same edge as the design's copies
  logic [7:0] sync_ff; // Software sync control
  logic [7:0] pat_ff; // Pattern control
  logic [7:0] mfc_ff; // Counter control
  logic wr_en;
  logic sync_req;
  logic [4:0] restart;
  assign wr_en = psel && penable && pwrite && pready;
  assign sync_req = sync_ff[6] ? sync_ff[7] : !sync_n;
  assign restart = mfc_ff[7] ? mfc_ff[6:2] : 5'h00;
  // Capture writes; unaligned addresses never match, so they are dropped here too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ff <= 8'h00;
      pat_ff <= 8'h00;
      mfc_ff <= 8'h00;
    end else if (wr_en) begin
      if (paddr == 8'h04) sync_ff <= pwdata[7:0];
      if (paddr == 8'h08) pat_ff <= pwdata[7:0];
      if (paddr == 8'h0C) mfc_ff <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ===================================================================
  // Assertions
  a_unmapped_error: assert property (psel && penable && !(paddr inside {8'h04, 8'h08, 8'h0C,
    8'h14, 8'h20}) |-> pslverr) else $error("no error on unmapped access");
  a_flip_level: assert property (lane_disp_flip == ($past(pat_ff[7:5]) == 3'h4 &&
    $past(pat_ff[4]))) else $error("disparity flip level wrong");
  a_wrap_boundary: assert property (mf_boundary && !$past(sysref) |-> mf_count == 5'h00)
    else $error("boundary not at count wrap");
  a_count_step: assert property ($changed(mf_count) && !$past(sysref) |->
    mf_count == $past(mf_count) + 5'h01) else $error("count jumped");
  a_sysref_restart: assert property (sysref && !pat_ff[3] |=> mf_count == $past(restart))
    else $error("restart value wrong");
  a_sysref_masked: assert property (sysref && pat_ff[3] |=> mf_count == $past(mf_count) ||
    mf_count == $past(mf_count) + 5'h01) else $error("masked restart acted");
  a_sync_kfill: assert property ((sync_req && pat_ff[7:5] == 3'h0) [*3] |->
    lane_is_k == '1 && lane_data == {LANES{8'hBC}}) else $error("no K fill");
  a_d215_fill: assert property ((!sync_req && pat_ff[7:5] == 3'h1) [*3] |->
    lane_is_k == '0 && lane_data == {LANES{8'hB5}}) else $error("no D21.5");
  a_rpat_nok: assert property ((!sync_req && pat_ff[7:5] == 3'h4) [*3] |->
    lane_is_k == '0) else $error("control char in jitter pattern");
  c_restart: cover property (sysref && !pat_ff[3]);
  c_boundary: cover property (mf_boundary);
  c_flip: cover property (lane_disp_flip);
endmodule : sltmc_link_checker
bind sltmc_link_ctrl sltmc_link_checker #(.LANES(LANES), .OCTETS_PER_FRAME(OCTETS_PER_FRAME))
  u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .sync_n, .sysref, .lane_data, .lane_is_k, .lane_disp_flip, .mf_count, .mf_boundary);

// *** sltmc_link_ctrl.sv ***
// Link-layer test pattern select, multiframe counter and alignment sequence control
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "sltmc_cfg.svh"
module sltmc_link_ctrl
  import sltmc_pkg::*;
#(
  parameter int LANES = 4,
  parameter int OCTETS_PER_FRAME = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_n,
  input wire logic sysref,
  input wire logic [LANES*8-1:0] sample_data,
  output logic [LANES*8-1:0] lane_data,
  output logic [LANES-1:0] lane_is_k,
  output logic lane_disp_flip,
  output logic [4:0] mf_count,
  output logic mf_boundary
);

  // =====================================================================
  // Register bus
  logic [7:0] sync_ctrl_ff;   // Software sync request and its enable
  logic [7:0] pattern_ff;     // Pattern select, disparity flip, SYSREF ignore
  logic [7:0] mfc_ctrl_ff;    // Preset enable, start value, alignment delay
  logic [7:0] scrambler_ff;   // Scrambler enable
  logic [5:0] reg_idx;        // Word index of the access
  logic idx_ok;               // Access lands on a mapped word
  logic apb_wr;               // Write takes effect this edge
  logic [7:0] status_byte;    // Live link state for software

  assign reg_idx = paddr[7:2];
  assign pready = 1'b1;  // Zero wait states: every access ends in its first access cycle
  assign apb_wr = psel & penable & pwrite & idx_ok;
  assign pslverr = psel & penable & ~idx_ok;

  // Address decode: the five mapped words, aligned accesses only
  always_comb begin
    unique case (reg_idx)
      `SLTMC_IDX_SYNC_CTRL, `SLTMC_IDX_PATTERN, `SLTMC_IDX_MFC_CTRL,
      `SLTMC_IDX_SCRAMBLER, `SLTMC_IDX_STATUS: idx_ok = (paddr[1:0] == 2'h0);
      default: idx_ok = 1'b0;
    endcase
  end

  // Register writes; the status word silently drops writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_ctrl_ff <= `SLTMC_RST_REG;
      pattern_ff <= `SLTMC_RST_REG;
      mfc_ctrl_ff <= `SLTMC_RST_REG;
      scrambler_ff <= `SLTMC_RST_REG;
    end else if (apb_wr) begin
      unique case (reg_idx)
        `SLTMC_IDX_SYNC_CTRL: sync_ctrl_ff <= pwdata[7:0] & `SLTMC_SYNC_RD_MASK;
        `SLTMC_IDX_PATTERN: pattern_ff <= pwdata[7:0] & `SLTMC_PAT_RD_MASK;
        `SLTMC_IDX_MFC_CTRL: mfc_ctrl_ff <= pwdata[7:0];
        `SLTMC_IDX_SCRAMBLER: scrambler_ff <= pwdata[7:0] & `SLTMC_SCR_RD_MASK;
        default: ;
      endcase
    end
  end

  // Read data is registered so it stands stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      unique case (reg_idx)
        `SLTMC_IDX_SYNC_CTRL: prdata <= {24'h00_0000, sync_ctrl_ff};
        `SLTMC_IDX_PATTERN: prdata <= {24'h00_0000, pattern_ff};
        `SLTMC_IDX_MFC_CTRL: prdata <= {24'h00_0000, mfc_ctrl_ff};
        `SLTMC_IDX_SCRAMBLER: prdata <= {24'h00_0000, scrambler_ff};
        `SLTMC_IDX_STATUS: prdata <= {24'h00_0000, status_byte};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // =====================================================================
  // Field decode
  sltmc_pat_e pat_sel;     // Active pattern code
  logic sync_req;          // Receiver or software asks for code-group sync
  logic preset_en;         // Restart from programmed value
  logic [4:0] start_val;   // Programmed restart value
  logic [1:0] ila_delay;   // Multiframes to wait before alignment sequence

  // Unused codes fall back to normal data; software must not write them
  always_comb begin
    unique case (pattern_ff[`SLTMC_PAT_SEL_HI:`SLTMC_PAT_SEL_LO])
      3'h1: pat_sel = SLTMC_PAT_D21_5;
      3'h2: pat_sel = SLTMC_PAT_K28_5;
      3'h3: pat_sel = SLTMC_PAT_ILA_LOOP;
      3'h4: pat_sel = SLTMC_PAT_RPAT;
      default: pat_sel = SLTMC_PAT_NORMAL;
    endcase
  end

  assign sync_req = sync_ctrl_ff[`SLTMC_SYNC_SW_EN_BIT] ? sync_ctrl_ff[`SLTMC_SYNC_SW_BIT]
                                                         : ~sync_n;
  assign preset_en = mfc_ctrl_ff[`SLTMC_PRESET_EN_BIT];
  assign start_val = mfc_ctrl_ff[`SLTMC_START_HI:`SLTMC_START_LO];
  assign ila_delay = mfc_ctrl_ff[`SLTMC_DELAY_HI:`SLTMC_DELAY_LO];

  // =====================================================================
  // Frame and multiframe counters
  localparam int OW = (OCTETS_PER_FRAME > 1) ? $clog2(OCTETS_PER_FRAME) : 1;
  localparam logic [OW-1:0] OCT_LAST = OW'(OCTETS_PER_FRAME - 1);
  logic [OW-1:0] octet_ff;   // Octet within frame
  logic [4:0] mf_count_ff;   // Local multiframe count
  logic restart;             // SYSREF restart that is not masked
  logic frame_end;           // Last octet of a frame
  logic mf_end;              // Last octet of a multiframe

  assign restart = sysref & ~pattern_ff[`SLTMC_MF_IGNORE_BIT];
  assign frame_end = (octet_ff == OCT_LAST);
  assign mf_end = frame_end & (mf_count_ff == `SLTMC_MF_LAST);
  assign mf_count = mf_count_ff;

  // Counter restarts on SYSREF unless the SYSREF ignore bit is set, otherwise advances one per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      octet_ff <= '0;
      mf_count_ff <= 5'h00;
    end else if (restart) begin
      octet_ff <= '0;
      mf_count_ff <= preset_en ? start_val : 5'h00;
    end else if (frame_end) begin
      octet_ff <= '0;
      mf_count_ff <= mf_count_ff + 5'h01;
    end else begin
      octet_ff <= octet_ff + OW'(1);
    end
  end

  // Boundary pulse lets the receiver side align its own counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_boundary <= 1'b0;
    end else begin
      mf_boundary <= mf_end & ~restart;
    end
  end

  // =====================================================================
  // Link state machine
  sltmc_state_e state_ff;
  sltmc_state_e nxt_state;
  logic [1:0] mf_left_ff;    // Multiframes left in delay or alignment phase
  logic [1:0] nxt_mf_left;
  logic ila_first;           // First multiframe of the alignment sequence

  always_comb begin
    nxt_state = state_ff;
    nxt_mf_left = mf_left_ff;
    if (sync_req) begin
      nxt_state = SLTMC_ST_CGS;
    end else begin
      unique case (state_ff)
        SLTMC_ST_CGS: begin
          nxt_state = SLTMC_ST_HOLD;
        end
        SLTMC_ST_HOLD: begin
          // Hold lasts until the count wraps after its last value; K28.5 continues through any delay
          if (mf_end && !restart) begin
            nxt_mf_left = ila_delay;
            nxt_state = (ila_delay == 2'h0) ? SLTMC_ST_ILAS : SLTMC_ST_DELAY;
            if (ila_delay == 2'h0) begin
              nxt_mf_left = `SLTMC_ILA_MF_LAST;
            end
          end
        end
        SLTMC_ST_DELAY: begin
          if (mf_end && !restart) begin
            nxt_mf_left = mf_left_ff - 2'h1;
            if (mf_left_ff == 2'h1) begin
              nxt_state = SLTMC_ST_ILAS;
              nxt_mf_left = `SLTMC_ILA_MF_LAST;
            end
          end
        end
        SLTMC_ST_ILAS: begin
          if (mf_end && !restart) begin
            nxt_mf_left = mf_left_ff - 2'h1;
            if (mf_left_ff == 2'h0) begin
              // Loop mode keeps sending alignment multiframes
              nxt_state = (pat_sel == SLTMC_PAT_ILA_LOOP) ? SLTMC_ST_ILAS
                                                          : SLTMC_ST_DATA;
              nxt_mf_left = `SLTMC_ILA_MF_LAST;
            end
          end
        end
        SLTMC_ST_DATA: begin
          nxt_state = SLTMC_ST_DATA;
        end
        default: nxt_state = SLTMC_ST_CGS;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SLTMC_ST_CGS;
      mf_left_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      mf_left_ff <= nxt_mf_left;
    end
  end

  assign ila_first = (mf_left_ff == `SLTMC_ILA_MF_LAST);
  assign status_byte = {state_ff, mf_count_ff};

  // =====================================================================
  // Random jitter pattern sequencer
  logic [3:0] rpat_idx_ff;   // Position in the 12-octet pattern
  logic [7:0] rpat_octet;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpat_idx_ff <= 4'h0;
    end else if (pat_sel != SLTMC_PAT_RPAT || rpat_idx_ff == `SLTMC_RPAT_LAST) begin
      rpat_idx_ff <= 4'h0;
    end else begin
      rpat_idx_ff <= rpat_idx_ff + 4'h1;
    end
  end

  // Fixed pattern table
  always_comb begin
    unique case (rpat_idx_ff)
      4'h0: rpat_octet = 8'hBE;
      4'h1: rpat_octet = 8'hD7;
      4'h2: rpat_octet = 8'h23;
      4'h3: rpat_octet = 8'h47;
      4'h4: rpat_octet = 8'h6B;
      4'h5: rpat_octet = 8'h8F;
      4'h6: rpat_octet = 8'hB3;
      4'h7: rpat_octet = 8'h14;
      4'h8: rpat_octet = 8'h5E;
      4'h9: rpat_octet = 8'hFB;
      4'hA: rpat_octet = 8'h35;
      default: rpat_octet = 8'h59;
    endcase
  end

  // Disparity flip only in random pattern mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_disp_flip <= 1'b0;
    end else begin
      lane_disp_flip <= (pat_sel == SLTMC_PAT_RPAT) & pattern_ff[`SLTMC_PAT_FLIP_BIT];
    end
  end

  // =====================================================================
  // Per-lane scrambler and output mux, same framing on every lane
  logic scr_en;
  logic first_octet;
  assign scr_en = scrambler_ff[`SLTMC_SCR_EN_BIT];
  assign first_octet = (octet_ff == '0) && (mf_count_ff == 5'h00);

  // Self-synchronous 1 + x^14 + x^15 scrambling of one octet, MSB first
  function automatic logic [22:0] sltmc_scramble(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] q;
    s = st;
    q = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      q[i] = d[i] ^ s[13] ^ s[14];
      s = {s[13:0], q[i]};
    end
    return {s, q};
  endfunction : sltmc_scramble

  for (genvar ln = 0; ln < LANES; ln++) begin : g_lane
    logic [14:0] scr_ff;     // Scrambler history of this lane
    logic [22:0] scr_out;
    logic [7:0] nxt_data;
    logic nxt_k;
    assign scr_out = sltmc_scramble(scr_ff, sample_data[ln*8 +: 8]);

    // Scrambler advances only in the data state with scrambling enabled
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        scr_ff <= 15'h7FFF;
      end else if (state_ff == SLTMC_ST_DATA && scr_en) begin
        scr_ff <= scr_out[22:8];
      end
    end

    // Character selection; test patterns override the link sequence
    always_comb begin
      nxt_data = `SLTMC_K28_5;
      nxt_k = 1'b1;
      if (pat_sel == SLTMC_PAT_D21_5) begin
        nxt_data = `SLTMC_D21_5;
        nxt_k = 1'b0;
      end else if (pat_sel == SLTMC_PAT_K28_5) begin
        nxt_data = `SLTMC_K28_5;
      end else if (pat_sel == SLTMC_PAT_RPAT) begin
        nxt_data = rpat_octet;
        nxt_k = 1'b0;
      end else begin
        unique case (state_ff)
          SLTMC_ST_ILAS: begin
            nxt_k = 1'b0;
            nxt_data = {3'h0, mf_count_ff};
            if (first_octet) begin
              nxt_data = `SLTMC_K28_0;
              nxt_k = 1'b1;
            end else if (mf_end) begin
              nxt_data = `SLTMC_K28_3;
              nxt_k = 1'b1;
            end else if (ila_first && octet_ff == '0 && mf_count_ff == 5'h01) begin
              nxt_data = `SLTMC_K28_4;
              nxt_k = 1'b1;
            end
          end
          SLTMC_ST_DATA: begin
            nxt_data = scr_en ? scr_out[7:0] : sample_data[ln*8 +: 8];
            nxt_k = 1'b0;
          end
          default: begin
            nxt_data = `SLTMC_K28_5;
            nxt_k = 1'b1;
          end
        endcase
      end
    end

    // Registered lane outputs
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lane_data[ln*8 +: 8] <= `SLTMC_K28_5;
        lane_is_k[ln] <= 1'b1;
      end else begin
        lane_data[ln*8 +: 8] <= nxt_data;
        lane_is_k[ln] <= nxt_k;
      end
    end
  end

endmodule : sltmc_link_ctrl

// *** sltmc_pkg.sv ***
// Types shared by the link test and multiframe control block
package sltmc_pkg;
  // =====================================================================
  // Pattern select codes
  typedef enum logic [2:0] {
    SLTMC_PAT_NORMAL = 3'h0,
    SLTMC_PAT_D21_5 = 3'h1,
    SLTMC_PAT_K28_5 = 3'h2,
    SLTMC_PAT_ILA_LOOP = 3'h3,
    SLTMC_PAT_RPAT = 3'h4
  } sltmc_pat_e;
  // =====================================================================
  // Link states, Gray coded along the usual path
  typedef enum logic [2:0] {
    SLTMC_ST_CGS = 3'h0,
    SLTMC_ST_HOLD = 3'h1,
    SLTMC_ST_DELAY = 3'h3,
    SLTMC_ST_ILAS = 3'h2,
    SLTMC_ST_DATA = 3'h6
  } sltmc_state_e;
endpackage : sltmc_pkg

// *** sltmc_rx_model.sv ***
// Receiver model: holds its sync request, releases it after a run of K28.5
`timescale 1ns/1ps
module sltmc_rx_model #(
  parameter int LANES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_req,
  input wire logic [LANES*8-1:0] lane_data,
  input wire logic [LANES-1:0] lane_is_k,
  output logic sync_n,
  output logic ilas_seen
);
  logic [2:0] kcnt_ff; // K28.5 run length, saturates at four
  // Count K28.5 on lane 0; a request clears the run so release needs fresh characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) kcnt_ff <= 3'h0;
    else if (hold_req) kcnt_ff <= 3'h0;
    else if (lane_is_k[0] && lane_data[7:0] == 8'hBC && kcnt_ff != 3'h4) kcnt_ff <= kcnt_ff + 3'h1;
  end
  // Sync pin is low (request) through reset and until the run is long enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sync_n <= 1'b0;
    else sync_n <= !(hold_req || kcnt_ff != 3'h4);
  end
  // First alignment character; a higher start value brings this sooner
  assign ilas_seen = lane_is_k[0] && lane_data[7:0] == 8'h1C;
endmodule : sltmc_rx_model
